// ==== dv/cpc_adapter_model.sv ====
// adapter-side optimizer partner
// assumes a run request is a level held until done is seen
`timescale 1ns/1ps
`default_nettype none
module cpc_adapter_model #(
  parameter int unsigned DLY = 20,
  parameter logic [5:0]  RES = 6'h2a
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       optimizerRun,
  output logic            optimizerDone,
  output logic      [5:0] optimizerResult
);
  int unsigned cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || !optimizerRun) cnt_q <= '0;
    else if (cnt_q < DLY) cnt_q <= cnt_q + 1;
  end
  assign optimizerDone = cnt_q == DLY;
  // junk outside done, so a capture at the wrong time shows
  assign optimizerResult = optimizerDone ? RES : ~RES;
endmodule : cpc_adapter_model
`default_nettype wire

// ==== dv/cpc_charge_path_chk.sv ====
// port assertions for the charge path controller
// assumes one clock domain and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module cpc_charge_path_chk
  import cpc_pkg::*;
#(parameter int unsigned SU_DLY_US = 5) (
  input wire logic core_clk, rst, psel, penable, pwrite, intPulse, optimizerRun,
  input wire logic [7:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata, prdata,
  input wire logic stepUpRun, stepUpFreqHigh, chargeRun, chargeReduce, stepUpEnablePin,
  input wire logic batAboveStepUpEn, inputBelowBatSleep, thermInStepUpWindow, batAboveExitLow,
  input wire logic batAboveExitHigh, inputOverCurrent, inputUnderVoltage, chargeEnablePin_n,
  input wire logic thermFault, timerFault
);
  logic [31:0] upCnt_q;
  wire suOk = stepUpEnablePin & batAboveStepUpEn & inputBelowBatSleep & thermInStepUpWindow;
  // raw pins lead the synchronised ones, so this count only over-estimates
  always_ff @(posedge core_clk) begin
    if (rst || !suOk) upCnt_q <= '0;
    else upCnt_q <= upCnt_q + 32'h1;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////
  a_int_single: assert property (intPulse |=> !intPulse)
    else $error("interrupt pulse too long");
  a_force_run: assert property (psel && penable && pwrite && paddr == OFS_CTRL && pstrb[0]
    && pwdata[B_OPT_FORCE] |-> ##[1:3] optimizerRun) else $error("forced run missing");
  a_freq_hold: assert property (stepUpRun ##1 stepUpRun |-> $stable(stepUpFreqHigh))
    else $error("frequency changed in step-up");
  a_boost_type: assert property (psel && penable && !pwrite && paddr == OFS_STATUS
    && stepUpRun && $past(stepUpRun) |-> prdata[4:2] == SRC_BOOST) else $error("bad type");
  a_chg_block: assert property ((chargeEnablePin_n || thermFault || timerFault)[*6]
    |=> !chargeRun) else $error("charging while blocked");
  a_reduce_on: assert property ((inputOverCurrent || inputUnderVoltage)[*6]
    |-> chargeReduce) else $error("no charge reduction");
  a_su_delay: assert property ($rose(stepUpRun) |-> upCnt_q >= (SU_DLY_US - 1) * TICK_CYC)
    else $error("step-up started early");
  a_su_exit: assert property ((!batAboveExitLow && !batAboveExitHigh)[*6] |=> !stepUpRun)
    else $error("step-up kept below exit");
  c_int: cover property (intPulse);
  c_boost: cover property ($rose(stepUpRun));
  c_opt: cover property ($rose(optimizerRun));
endmodule : cpc_charge_path_chk
bind cpc_charge_path cpc_charge_path_chk #(.SU_DLY_US(SU_DLY_US)) u_chk (.*);
`default_nettype wire

// ==== dv/cpc_charge_path_tb_top.sv ====
// bench for cpc_charge_path: APB tasks plus pin stimulus
// assumes the step-up delay is cut to five ticks
`timescale 1ns/1ps
`default_nettype none
module cpc_charge_path_tb_top;
  import cpc_pkg::*;
  logic core_clk = '0, rst = 1'h1, psel = '0, penable = '0, pwrite = '0, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, stepUpVoltage;
  logic [5:0] optimizerResult, effInputLimit, extLimitPin = 6'h3f;
  logic [2:0] minSysVoltage, srcType = '0;
  logic [1:0] chargeCurSel;
  logic pready, pslverr, optimizerDone, optimizerRun, stepUpRun, stepUpFreqHigh, stepUpPulseSkip;
  logic chargeReduce, batterySwitchOn, chargeRun, safetyTick, statusPinOut, statusPinOe, intPulse;
  logic srcDetectDone = '0, batAboveStepUpEn = '0, inputBelowBatSleep = '0, stepUpEnablePin = '0;
  logic thermInStepUpWindow = '0, batAboveExitLow = '0, batAboveExitHigh = '0, sysInMinReg = '0;
  logic inputOverCurrent = '0, inputUnderVoltage = '0, sysBelowBat = '0, batBelowDepletion = '0;
  logic chargeEnablePin_n = 1'h1, converterStarted = '0, thermFault = '0, timerFault = '0;
  logic thermalReg = '0, chgCurBelowTerm = '0, batAboveRechgLow = '0, batAboveRechgHigh = '0;
  logic batBelow2v = '0, batBelow3v = '0;
  int errorCnt = 0, nTests = 0;
  cpc_charge_path #(.SU_DLY_US(5), .BLINK_TK(3)) uut (.*);
  cpc_adapter_model model (.*);
  always #2 core_clk = ~core_clk;
  ////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= '0;
  endtask : apb
  task automatic chk(input logic [31:0] g, e);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(ref logic s);
    for (int i = 0; i < 3000 && s !== 1'h1; i++) @(posedge core_clk);
    chk(32'(s), 32'h1);
  endtask : wt
  // lets pin changes clear the synchronisers, then reads status
  task automatic rs;
    repeat (10) @(posedge core_clk);
    apb(1'h0, OFS_STATUS, '0);
  endtask : rs
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    #100us;
    errorCnt++;
    summarize();
  end
  ////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= '0;
    apb(1'h0, OFS_CTRL, '0);
    chk(rd, CTRL_RST);
    apb(1'h0, OFS_LIMIT, '0);
    chk(rd, LIMIT_RST);
    chk(32'({stepUpVoltage, minSysVoltage, stepUpPulseSkip}), 32'h9b);
    apb(1'h0, OFS_CHARGE, '0);
    chk(rd, CHARGE_RST);
    apb(1'h0, 8'h40, '0);
    chk(32'(er), 32'h1);
    $display("defaults done");
    apb(1'h1, OFS_CTRL, CTRL_RST | 32'h2);
    wt(intPulse);
    rs;
    chk(32'(rd[21:16]), 32'h2a);
    apb(1'h1, OFS_CTRL, 32'hc);
    @(posedge core_clk);
    extLimitPin <= 6'h2;
    rs;
    chk(32'(rd[21:16]), 32'h2);
    apb(1'h1, OFS_CTRL, 32'h8);
    rs;
    chk(32'(rd[21:16]), 32'h8);
    $display("limit done");
    @(posedge core_clk);
    {sysInMinReg, converterStarted, chargeEnablePin_n, batBelow3v} <= 4'hd;
    rs;
    chk(32'(rd[1:0]), 32'(PH_PRE));
    chk(32'(statusPinOe), 32'h1);
    chk(32'({rd[5], batterySwitchOn, chargeCurSel}), 32'hd);
    wt(safetyTick);
    chk(32'(safetyTick), 32'h1);
    @(posedge core_clk);
    {batBelow3v, thermalReg, chgCurBelowTerm, batAboveRechgLow} <= 4'h7;
    rs;
    chk(32'(rd[1:0]), 32'(PH_FAST));
    @(posedge core_clk);
    thermalReg <= '0;
    wt(intPulse);
    chk(32'(intPulse), 32'h1);
    rs;
    chk(32'(rd[1:0]), 32'(PH_DONE));
    chk(32'(statusPinOe), 32'h0);
    @(posedge core_clk);
    {chgCurBelowTerm, batAboveRechgLow} <= '0;
    rs;
    chk(32'(rd[1:0]), 32'(PH_FAST));
    @(posedge core_clk);
    chargeEnablePin_n <= 1'h1;
    rs;
    chk(32'(rd[1:0]), 32'(PH_OFF));
    $display("charge done");
    @(posedge core_clk);
    {batAboveStepUpEn, inputBelowBatSleep, stepUpEnablePin, thermInStepUpWindow} <= 4'hf;
    batAboveExitLow <= 1'h1;
    apb(1'h1, OFS_CTRL, CTRL_RST | 32'h20);
    apb(1'h1, OFS_CTRL, CTRL_RST | 32'h60);
    wt(stepUpRun);
    rs;
    chk(32'(rd[4:2]), 32'(SRC_BOOST));
    chk(32'(stepUpFreqHigh), 32'h0);
    @(posedge core_clk);
    batAboveExitLow <= '0;
    rs;
    chk(32'(stepUpRun), 32'h0);
    $display("step-up done");
    summarize();
  end
endmodule : cpc_charge_path_tb_top
`default_nettype wire

// ==== rtl/cpc_charge_path.sv ====
// charge path controller: optimizer sequencing, input limit selection, boost control,
// power-path flags and the autonomous charge-cycle sequencer, with an APB register file
// assumes analog comparators and detectors outside drive the level inputs asynchronously
`timescale 1ns/1ps
`default_nettype none
module cpc_charge_path
  import cpc_pkg::*;
#(
  parameter int unsigned LIM_W    = 6,
  parameter int unsigned SU_DLY_US = STEPUP_DLY_US,
  parameter int unsigned BLINK_TK  = BLINK_US
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [2:0]       srcType,
  input  wire logic             srcDetectDone,
  input  wire logic             optimizerDone,
  input  wire logic [LIM_W-1:0] optimizerResult,
  input  wire logic [LIM_W-1:0] extLimitPin,
  input  wire logic             batAboveStepUpEn,
  input  wire logic             inputBelowBatSleep,
  input  wire logic             stepUpEnablePin,
  input  wire logic             thermInStepUpWindow,
  input  wire logic             batAboveExitLow,
  input  wire logic             batAboveExitHigh,
  input  wire logic             sysInMinReg,
  input  wire logic             inputOverCurrent,
  input  wire logic             inputUnderVoltage,
  input  wire logic             sysBelowBat,
  input  wire logic             batBelowDepletion,
  input  wire logic             chargeEnablePin_n,
  input  wire logic             converterStarted,
  input  wire logic             thermFault,
  input  wire logic             timerFault,
  input  wire logic             thermalReg,
  input  wire logic             chgCurBelowTerm,
  input  wire logic             batAboveRechgLow,
  input  wire logic             batAboveRechgHigh,
  input  wire logic             batBelow2v,
  input  wire logic             batBelow3v,
  output logic                  optimizerRun,
  output logic      [LIM_W-1:0] effInputLimit,
  output logic                  stepUpRun,
  output logic                  stepUpFreqHigh,
  output logic                  stepUpPulseSkip,
  output logic      [3:0]       stepUpVoltage,
  output logic      [2:0]       minSysVoltage,
  output logic                  chargeReduce,
  output logic                  batterySwitchOn,
  output logic                  chargeRun,
  output logic      [1:0]       chargeCurSel,
  output logic                  safetyTick,
  output logic                  statusPinOut,
  output logic                  statusPinOe,
  output logic                  intPulse
);

  initial begin
    if (LIM_W < 1 || LIM_W > 8) $error("cpc_charge_path: LIM_W must be 1 to 8");
    if (SU_DLY_US < 1 || BLINK_TK < 1) $error("cpc_charge_path: counts must be nonzero");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  localparam int unsigned NLVL = 23 + 2 * LIM_W + 3;

  logic [NLVL-1:0]  pinRaw;
  logic [NLVL-1:0]  pinLvl;
  logic [2:0]       srcTypeS;
  logic [LIM_W-1:0] optResS;
  logic [LIM_W-1:0] extLimS;
  logic detDoneS, optDoneS, suBatOk, suInLow, suPin, suTherm, exitLo, exitHi;
  logic minRegS, overCurS, underVoltS, sysLowS, depleteS, ceNS, convS, thFltS;
  logic tmFltS, thRegS, belowTermS, rchgLoS, rchgHiS, below2vS, below3vS;

  assign pinRaw = {srcType, optimizerResult, extLimitPin, srcDetectDone, optimizerDone,
                   batAboveStepUpEn, inputBelowBatSleep, stepUpEnablePin,
                   thermInStepUpWindow, batAboveExitLow, batAboveExitHigh, sysInMinReg,
                   inputOverCurrent, inputUnderVoltage, sysBelowBat, batBelowDepletion,
                   chargeEnablePin_n, converterStarted, thermFault, timerFault, thermalReg,
                   chgCurBelowTerm, batAboveRechgLow, batAboveRechgHigh, batBelow2v,
                   batBelow3v};

  assign {srcTypeS, optResS, extLimS, detDoneS, optDoneS, suBatOk, suInLow, suPin, suTherm,
          exitLo, exitHi, minRegS, overCurS, underVoltS, sysLowS, depleteS, ceNS, convS,
          thFltS, tmFltS, thRegS, belowTermS, rchgLoS, rchgHiS, below2vS,
          below3vS} = pinLvl;

  cpc_pin_sync #(.WIDTH(NLVL)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (pinRaw),
    .levelOut (pinLvl)
  );

  logic detDone_q;
  logic optDone_q;
  logic detRise;
  logic optRise;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      detDone_q <= 1'b0;
      optDone_q <= 1'b0;
    end else begin
      detDone_q <= detDoneS;
      optDone_q <= optDoneS;
    end
  end

  assign detRise = detDoneS & ~detDone_q;
  assign optRise = optDoneS & ~optDone_q;

  //////////////////////////////////////////////////////////////////////////////
  // register file over APB, single-cycle answer

  logic [31:0] ctrl_q;
  logic [31:0] limit_q;
  logic [31:0] charge_q;
  logic [31:0] wmask;
  logic        wr;
  logic        hitCtrl, hitLimit, hitCharge, hitStatus, hitOptRes, hit;

  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr    = psel & penable & pwrite;
  assign hitCtrl   = (paddr == OFS_CTRL);
  assign hitLimit  = (paddr == OFS_LIMIT);
  assign hitCharge = (paddr == OFS_CHARGE);
  assign hitStatus = (paddr == OFS_STATUS);
  assign hitOptRes = (paddr == OFS_OPTRES);
  assign hit       = hitCtrl | hitLimit | hitCharge | hitStatus | hitOptRes;

  logic [31:0] ctrlWr;
  logic        optForceSet;

  always_comb begin
    ctrlWr = ((ctrl_q & ~wmask) | (pwdata & wmask)) & CTRL_MASK;
    // frequency must not change under a running boost configuration
    ctrlWr[B_SU_FREQ] = ctrl_q[B_SU_CFG] ? ctrl_q[B_SU_FREQ] : ctrlWr[B_SU_FREQ];
    ctrlWr[B_OPT_FORCE] = 1'b0;
  end

  assign optForceSet = wr & hitCtrl & pstrb[0] & pwdata[B_OPT_FORCE];

  logic optEnd;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr && hitCtrl) begin
        ctrl_q <= ctrlWr;
      end
      // software set wins over the run-complete clear
      if (optForceSet) begin
        ctrl_q[B_OPT_FORCE] <= 1'b1;
      end else if (optEnd) begin
        ctrl_q[B_OPT_FORCE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      limit_q <= LIMIT_RST;
    end else if (wr && hitLimit) begin
      limit_q <= ((limit_q & ~wmask) | (pwdata & wmask)) & LIMIT_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      charge_q <= CHARGE_RST;
    end else if (wr && hitCharge) begin
      charge_q <= ((charge_q & ~wmask) | (pwdata & wmask)) & CHARGE_MASK;
    end
  end

  logic [31:0] statusWord;
  logic [1:0]  phase;
  logic [2:0]  inTypeStat;
  logic        vRegFlag;
  logic        iRegFlag;
  logic        suppl_q;
  logic [LIM_W-1:0] optLim_q;

  assign statusWord = {8'h00, 2'h0, effInputLimit, 5'h00, optimizerRun, stepUpRun,
                       suppl_q, iRegFlag, vRegFlag, minRegS, inTypeStat, phase};

  assign pready = 1'b1;

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = psel & penable & ~hit;
    if (hitCtrl) begin
      prdata = ctrl_q;
    end else if (hitLimit) begin
      prdata = limit_q;
    end else if (hitCharge) begin
      prdata = charge_q;
    end else if (hitStatus) begin
      prdata = statusWord;
    end else if (hitOptRes) begin
      prdata = {{(32 - LIM_W){1'b0}}, optLim_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input current optimizer and effective limit

  logic optAutoStart;
  logic runOpt_q;

  assign optAutoStart = ctrl_q[B_OPT_EN] & detRise &
                        ((srcTypeS == SRC_DCP) | (srcTypeS == SRC_HV));
  assign optEnd = runOpt_q & optRise;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      runOpt_q <= 1'b0;
      optLim_q <= '0;
    end else if (optEnd) begin
      runOpt_q <= 1'b0;
      optLim_q <= optResS;
    end else if (optAutoStart || ctrl_q[B_OPT_FORCE]) begin
      runOpt_q <= 1'b1;
    end
  end

  assign optimizerRun = runOpt_q;

  logic [LIM_W-1:0] baseLim;
  logic [LIM_W-1:0] effLim_d;

  always_comb begin
    baseLim  = ctrl_q[B_OPT_EN] ? optLim_q : limit_q[F_HOSTLIM +: LIM_W];
    effLim_d = baseLim;
    if (ctrl_q[B_LIMPIN_EN] && extLimS < baseLim) begin
      effLim_d = extLimS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      effInputLimit <= '0;
    end else begin
      effInputLimit <= effLim_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // microsecond tick shared by boost delay, blink and safety timer

  localparam int unsigned TW = $clog2(TICK_CYC);
  logic [TW-1:0] tickCnt_q;
  logic          tick;

  assign tick = (tickCnt_q == TW'(TICK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // boost mode

  localparam int unsigned DW = $clog2(SU_DLY_US + 1);
  logic [DW-1:0] suDly_q;
  logic          suReq;
  logic          suExitOk;
  logic          suRun_q;

  assign suReq = suBatOk & suInLow & suPin & ctrl_q[B_SU_CFG] & suTherm;
  assign suExitOk = ctrl_q[B_EXIT_SEL] ? exitHi : exitLo;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      suDly_q <= '0;
      suRun_q <= 1'b0;
    end else if (!suReq && !suRun_q) begin
      suDly_q <= '0;
    end else if (suRun_q) begin
      // once running, only the exit threshold, a dropped enable or leaving the thermal window ends boost
      if (!suExitOk || !suPin || !ctrl_q[B_SU_CFG] || !suTherm) begin
        suRun_q <= 1'b0;
        suDly_q <= '0;
      end
    end else if (suDly_q == DW'(SU_DLY_US)) begin
      suRun_q <= 1'b1;
    end else if (tick) begin
      suDly_q <= suDly_q + 1'b1;
    end
  end

  assign stepUpRun       = suRun_q;
  assign stepUpFreqHigh  = ctrl_q[B_SU_FREQ];
  assign stepUpPulseSkip = ~ctrl_q[B_SU_PSDIS];
  assign stepUpVoltage   = limit_q[F_SUVOLT +: 4];
  assign inTypeStat      = suRun_q ? SRC_BOOST : srcTypeS;

  //////////////////////////////////////////////////////////////////////////////
  // power path

  assign minSysVoltage = limit_q[F_MINSYS +: 3];
  assign vRegFlag      = underVoltS;
  assign iRegFlag      = overCurS;
  assign chargeReduce  = underVoltS | overCurS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      suppl_q <= 1'b0;
    end else if (depleteS) begin
      suppl_q <= 1'b0;
    end else if (sysLowS) begin
      suppl_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // charge cycle sequencer

  cpc_chg_t chg_q;
  cpc_chg_t chg_d;
  logic     chgAllowed;
  logic     startOk;
  logic     inReg;
  logic     rechgLow;
  logic     termNow;

  assign chgAllowed = ctrl_q[B_CHG_EN] & ~ceNS;
  assign startOk = convS & chgAllowed & (charge_q[F_FCC +: 7] != 7'h00) & ~thFltS &
                   ~tmFltS & ~ctrl_q[B_SW_OFF];
  assign inReg    = underVoltS | overCurS | thRegS;
  assign rechgLow = ctrl_q[B_RECHG_SEL] ? ~rchgHiS : ~rchgLoS;
  assign termNow  = belowTermS & ~rechgLow & ~inReg;

  always_comb begin
    chg_d = chg_q;
    case (chg_q)
      CHG_IDLE: begin
        if (startOk) begin
          chg_d = below3vS ? CHG_PRE : CHG_FAST;
        end
      end
      CHG_PRE: begin
        if (!startOk) begin
          chg_d = CHG_IDLE;
        end else if (!below3vS) begin
          chg_d = CHG_FAST;
        end
      end
      CHG_FAST: begin
        if (!startOk) begin
          chg_d = CHG_IDLE;
        end else if (termNow) begin
          chg_d = CHG_DONE;
        end
      end
      CHG_DONE: begin
        // dropping the enable returns to idle so re-enabling starts afresh
        if (!chgAllowed) begin
          chg_d = CHG_IDLE;
        end else if (rechgLow && startOk) begin
          chg_d = below3vS ? CHG_PRE : CHG_FAST;
        end
      end
      default: chg_d = CHG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chg_q <= CHG_IDLE;
    end else begin
      chg_q <= chg_d;
    end
  end

  always_comb begin
    case (chg_q)
      CHG_PRE:  phase = PH_PRE;
      CHG_FAST: phase = PH_FAST;
      CHG_DONE: phase = PH_DONE;
      default:  phase = PH_OFF;
    endcase
  end

  logic charging;

  assign charging  = (chg_q == CHG_PRE) | (chg_q == CHG_FAST);
  assign chargeRun = charging;
  assign batterySwitchOn = ~ctrl_q[B_SW_OFF] & (charging | suppl_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chargeCurSel <= CUR_FAST;
    end else if (below2vS) begin
      chargeCurSel <= CUR_SHORT;
    end else if (below3vS) begin
      chargeCurSel <= CUR_PRE;
    end else begin
      chargeCurSel <= CUR_FAST;
    end
  end

  // safety timer base: every other tick while the current is held back by regulation
  logic halfPh_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      halfPh_q <= 1'b0;
    end else if (tick) begin
      halfPh_q <= ~halfPh_q;
    end
  end

  assign safetyTick = charging & tick & (~inReg | halfPh_q);

  //////////////////////////////////////////////////////////////////////////////
  // status pin and interrupt

  localparam int unsigned BW = $clog2(BLINK_TK + 1);
  logic [BW-1:0] blinkCnt_q;
  logic          blink_q;
  logic          fault;

  assign fault = chgAllowed & (thFltS | tmFltS);

  always_ff @(posedge core_clk) begin
    if (rst || !fault) begin
      blinkCnt_q <= '0;
      blink_q    <= 1'b0;
    end else if (tick) begin
      if (blinkCnt_q == BW'(BLINK_TK - 1)) begin
        blinkCnt_q <= '0;
        blink_q    <= ~blink_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 1'b1;
      end
    end
  end

  // open drain: enable high pulls the pin low; released means high
  assign statusPinOut = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst || ctrl_q[B_STATUS_PIN_DISABLE]) begin
      statusPinOe <= 1'b0;
    end else if (fault) begin
      statusPinOe <= ~blink_q;
    end else begin
      statusPinOe <= charging;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      intPulse <= 1'b0;
    end else begin
      intPulse <= (chg_d == CHG_DONE && chg_q != CHG_DONE) | optEnd;
    end
  end

endmodule : cpc_charge_path
`default_nettype wire

// ==== rtl/cpc_pin_sync.sv ====
// three-stage synchroniser for a group of pin levels
// assumes every bit is an independent level from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module cpc_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  initial begin
    if (WIDTH < 1) $error("cpc_pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge core_clk) begin
    meta_q <= pinIn;
    s2_q   <= meta_q;
    s3_q   <= s2_q;
  end

  // a bit changes only once stages two and three agree, filtering one-cycle glitches
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (rst) begin
        levelOut[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        levelOut[i] <= s3_q[i];
      end
    end
  end

endmodule : cpc_pin_sync
`default_nettype wire

// ==== rtl/cpc_pkg.sv ====
// constants shared by the charge path controller, its checker and its bench
// assumes a single 250 MHz core clock and a synchronous active-high reset
//
// Summary of operation
// - optimizer enable bit resets to 1; writing 0 disables the optimizer
// - when enabled, the optimizer runs after dedicated-port or high-voltage source detection
// - the force bit starts an optimizer run whatever source was detected
// - effective limit is optimizer result or host limit, clamped by limit pin
// - boost starts only when all five conditions hold, after 30 ms
// - boost frequency selectable; its writes ignored while boost config set; pulse-skip optional
// - in boost input type reads 111; output voltage default 5.126 V, adjustable
// - boost held while battery above selected exit threshold, ends below it
// - system rail regulated at or above minimum-system setting, default 3.5 V
// - minimum-system flag high only while that regulation is active
// - input overload reduces charge current and sets voltage or current flag
// - battery switch on when rail below battery; off below depletion threshold
// - charging enabled when enable bit is 1 and active-low pin is low
// - charge parameters reset to 4.352 V, 2.048 A, 128 mA, 256 mA, 12 h
// - new cycle needs converter, enable, nonzero current, no faults, no force-off
// - terminate on low current and high voltage, never in input or thermal regulation
// - after done, recharge below selected threshold or enable toggle starts a cycle
// - status pin low charging, high done or off, blinking on fault, disable option
// - phase codes 00 off, 01 pre, 10 fast, 11 done; interrupt on completion
// - current chosen by battery voltage: short below 2 V, pre to 3 V, fast above
// - in input or thermal regulation, inhibit termination and halve safety timer rate
package cpc_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned TICK_NS        = 1000;
  localparam int unsigned TICK_CYC       = TICK_NS * CLK_MHZ / 1000;
  localparam int unsigned STEPUP_DLY_MS  = 30;
  localparam int unsigned STEPUP_DLY_US  = STEPUP_DLY_MS * 1000;
  localparam int unsigned BLINK_MS       = 500;
  localparam int unsigned BLINK_US       = BLINK_MS * 1000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_CHARGE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_OPTRES = 8'h10;

  // control register bits
  localparam int unsigned B_OPT_EN    = 0;
  localparam int unsigned B_OPT_FORCE = 1;
  localparam int unsigned B_LIMPIN_EN = 2;
  localparam int unsigned B_CHG_EN    = 3;
  localparam int unsigned B_STATUS_PIN_DISABLE  = 4;
  localparam int unsigned B_SU_CFG    = 5;
  localparam int unsigned B_SU_FREQ   = 6;
  localparam int unsigned B_SU_PSDIS  = 7;
  localparam int unsigned B_SW_OFF    = 8;
  localparam int unsigned B_RECHG_SEL = 9;
  localparam int unsigned B_EXIT_SEL  = 10;
  localparam int unsigned B_SU_HOT    = 11;
  localparam int unsigned B_SU_COLD   = 13;
  localparam logic [31:0] CTRL_RST    = 32'h0000_000d;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_7fff;

  // limit register fields
  localparam int unsigned F_HOSTLIM = 0;
  localparam int unsigned F_MINSYS  = 8;
  localparam int unsigned F_SUVOLT  = 12;
  localparam logic [31:0] LIMIT_RST  = 32'h0000_9508;
  localparam logic [31:0] LIMIT_MASK = 32'h0000_f73f;

  // charge parameter fields; defaults give 4.352 V, 2.048 A, 128 mA, 256 mA, 12 h
  localparam int unsigned F_FCC   = 0;
  localparam int unsigned F_PRE   = 8;
  localparam int unsigned F_TERM  = 12;
  localparam int unsigned F_VREG  = 16;
  localparam int unsigned F_TMR   = 22;
  localparam int unsigned B_TPROF = 24;
  localparam logic [31:0] CHARGE_RST  = 32'h01a0_3120;
  localparam logic [31:0] CHARGE_MASK = 32'h01ff_ff7f;

  localparam logic [2:0] SRC_DCP   = 3'h3;
  localparam logic [2:0] SRC_HV    = 3'h4;
  localparam logic [2:0] SRC_BOOST = 3'h7;

  localparam logic [1:0] PH_OFF  = 2'h0;
  localparam logic [1:0] PH_PRE  = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;

  localparam logic [1:0] CUR_SHORT = 2'h0;
  localparam logic [1:0] CUR_PRE   = 2'h1;
  localparam logic [1:0] CUR_FAST  = 2'h2;

  typedef enum logic [3:0] {
    CHG_IDLE = 4'b0001,
    CHG_PRE  = 4'b0010,
    CHG_FAST = 4'b0100,
    CHG_DONE = 4'b1000
  } cpc_chg_t;

endpackage : cpc_pkg
